// ---- core/pcr_consts.svh ----
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH

// register index on the plain register port
`define PCR_ADDR_W      4
`define PCR_OFF_CTRL    4'h0
`define PCR_OFF_STATUS  4'h1
`define PCR_OFF_MASK    4'h2
`define PCR_OFF_SERTOP  4'h3

// power_control field positions
`define PCR_BIT_IDLE    0
`define PCR_BIT_PWR_DOWN 1
`define PCR_BIT_GF_LO   2
`define PCR_BIT_GF_HI   3
`define PCR_BIT_OFF_FLAG 4
`define PCR_BIT_RSVD    5
`define PCR_BIT_FESEL   6
`define PCR_BIT_TOP     7

// serial top-bit access register: value in bit 0
`define PCR_BIT_SERTOP  0

// event status / mask layout
`define PCR_EV_W        3
`define PCR_EV_IDLE_END 0
`define PCR_EV_WARM     1
`define PCR_EV_FRAME    2
`define PCR_EV_ZERO     3'h0

// cold reset image of power_control: 00x1 0000, reserved bit taken as 0
`define PCR_CTRL_RST    8'h10
`define PCR_BYTE_ZERO   8'h00

`endif

// ---- core/pcr_pkg.sv ----
`include "pcr_consts.svh"

package pcr_pkg;
  typedef logic [7:0]               byte_t;
  typedef logic [`PCR_EV_W-1:0]     ev_t;
  typedef logic [`PCR_ADDR_W-1:0]   addr_t;
endpackage

// ---- core/evt_if.sv ----
`timescale 1ns/10ps
`include "pcr_consts.svh"

interface evt_if;
  pcr_pkg::ev_t  evt;
  logic          wr_clr;
  logic          wr_mask;
  pcr_pkg::ev_t  wdata;
  pcr_pkg::ev_t  status;
  pcr_pkg::ev_t  mask;
  logic          irq;

  modport core (
    input  evt,
    input  wr_clr,
    input  wr_mask,
    input  wdata,
    output status,
    output mask,
    output irq
  );

  modport user (
    output evt,
    output wr_clr,
    output wr_mask,
    output wdata,
    input  status,
    input  mask,
    input  irq
  );
endinterface

// ---- core/sync2.sv ----
`timescale 1ns/10ps

module sync2 (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ---- core/event_status.sv ----
`timescale 1ns/10ps
`include "pcr_consts.svh"

module event_status (
  input  wire logic clk,
  input  wire logic rst_b,
  evt_if.core       ev
);
  pcr_pkg::ev_t status_q;
  pcr_pkg::ev_t mask_q;
  logic         irq_q;

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= `PCR_EV_ZERO;
    end else begin
      status_q <= (status_q & ~(ev.wr_clr ? ev.wdata : `PCR_EV_ZERO))
                  | ev.evt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= `PCR_EV_ZERO;
    end else if (ev.wr_mask) begin
      mask_q <= ev.wdata;
    end
  end

  always_comb begin
    irq_q = |(status_q & mask_q);
  end

  assign ev.status = status_q;
  assign ev.mask   = mask_q;
  assign ev.irq    = irq_q;
endmodule

// ---- core/power_control_register.sv ----
// How it works
// R1: after reset power_control reads 00x1 0000; flag set, others cleared.
// R2: only a cold power-on reset forces the power-off flag to one.
// R3: a warm reset leaves the power-off flag exactly as it was.
// R4: bit 5 is reserved; software must not write one; read value undefined.
// R5: bits 3 and 2 are software-only flags with no hardware effect.
// R6: writing one to bit 1 enters power-down; any reset clears it.
// R7: writing one to bit 0 enters idle; interrupt or reset clears it.
// R8: bit 6 picks serial mode bit zero or framing error for the top bit.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "pcr_consts.svh"

module power_control_register (
  input  wire logic            CLK,
  input  wire logic            RST_B,
  input  wire logic            WARM_RST,
  input  wire logic            INT_EVENT,
  input  wire logic            FRAME_ERR_EVENT,
  input  wire pcr_pkg::addr_t  ADDR,
  input  wire pcr_pkg::byte_t  WDATA,
  input  wire logic            WR,
  input  wire logic            RD,
  output pcr_pkg::byte_t       RDATA,
  output logic                 IDLE_MODE,
  output logic                 POWER_DOWN_MODE,
  output logic                 SERIAL_MODE_BIT_ZERO,
  output logic                 FRAMING_ERROR_FLAG,
  output logic                 IRQ
);

  logic           warm_rst;
  logic           warm_rst_d_q;
  logic           idle_q;
  logic           pwr_down_q;
  logic           gf_lo_q;
  logic           gf_hi_q;
  logic           off_flag_q;
  logic           rsvd_q;
  logic           fesel_q;
  logic           mode0_q;
  logic           ferr_q;
  pcr_pkg::byte_t rdata_q;
  pcr_pkg::byte_t rdata_d;
  pcr_pkg::byte_t ctrl_view;
  pcr_pkg::ev_t   ev_now;
  logic           ctrl_wr;
  logic           ctrl_rd;
  logic           sertop_wr;
  logic           sertop_rd;
  logic           status_wr;
  logic           mask_wr;
  logic           sertop_bit;

  evt_if evb ();

  // warm reset is a pin, so it is synchronised before use
  sync2 u_warm_sync (
    .clk   (CLK),
    .rst_b (RST_B),
    .din   (WARM_RST),
    .dout  (warm_rst)
  );

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      warm_rst_d_q <= 1'b0;
    end else begin
      warm_rst_d_q <= warm_rst;
    end
  end

  // address decode
  always_comb begin
    ctrl_wr   = 1'b0;
    ctrl_rd   = 1'b0;
    sertop_wr = 1'b0;
    sertop_rd = 1'b0;
    status_wr = 1'b0;
    mask_wr   = 1'b0;
    if (ADDR == `PCR_OFF_CTRL) begin
      ctrl_wr = WR;
      ctrl_rd = RD;
    end else if (ADDR == `PCR_OFF_STATUS) begin
      status_wr = WR;
    end else if (ADDR == `PCR_OFF_MASK) begin
      mask_wr = WR;
    end else if (ADDR == `PCR_OFF_SERTOP) begin
      sertop_wr = WR;
      sertop_rd = RD;
    end
  end

  // idle: hardware end wins over a software set in the same cycle
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      idle_q <= 1'b0;                                      // [R1] [R7]
    end else if (warm_rst || INT_EVENT) begin
      idle_q <= 1'b0;                                      // [R7]
    end else if (ctrl_wr) begin
      idle_q <= WDATA[`PCR_BIT_IDLE];                      // [R7]
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pwr_down_q <= 1'b0;                                  // [R1] [R6]
    end else if (warm_rst) begin
      pwr_down_q <= 1'b0;                                  // [R6]
    end else if (ctrl_wr) begin
      pwr_down_q <= WDATA[`PCR_BIT_PWR_DOWN];              // [R6]
    end
  end

  // general flags: plain storage, read only by the control register read-back
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      gf_lo_q <= 1'b0;                                     // [R1]
      gf_hi_q <= 1'b0;
    end else if (warm_rst) begin
      gf_lo_q <= 1'b0;                                     // [R1]
      gf_hi_q <= 1'b0;
    end else if (ctrl_wr) begin
      gf_lo_q <= WDATA[`PCR_BIT_GF_LO];                    // [R5]
      gf_hi_q <= WDATA[`PCR_BIT_GF_HI];                    // [R5]
    end
  end

  // power-off flag: cold reset sets it, warm reset never touches it
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      off_flag_q <= 1'b1;                                  // [R2]
    end else if (ctrl_wr) begin
      off_flag_q <= WDATA[`PCR_BIT_OFF_FLAG];              // [R3]
    end
  end

  // reserved bit kept as written so a read is at least repeatable
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rsvd_q <= 1'b0;                                      // [R4]
    end else if (ctrl_wr) begin
      rsvd_q <= WDATA[`PCR_BIT_RSVD];                      // [R4]
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fesel_q <= 1'b0;                                     // [R1]
    end else if (warm_rst) begin
      fesel_q <= 1'b0;
    end else if (ctrl_wr) begin
      fesel_q <= WDATA[`PCR_BIT_FESEL];                    // [R8]
    end
  end

  // serial top bit: one address, two storage bits behind it
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode0_q <= 1'b0;
    end else if (warm_rst) begin
      mode0_q <= 1'b0;
    end else if (sertop_wr && !fesel_q) begin
      mode0_q <= WDATA[`PCR_BIT_SERTOP];                   // [R8]
    end
  end

  // framing error: set by the receiver, a set beats a software clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ferr_q <= 1'b0;
    end else if (warm_rst) begin
      ferr_q <= 1'b0;
    end else if (FRAME_ERR_EVENT) begin
      ferr_q <= 1'b1;
    end else if (sertop_wr && fesel_q) begin
      ferr_q <= WDATA[`PCR_BIT_SERTOP];                    // [R8]
    end
  end

  always_comb begin
    sertop_bit = fesel_q ? ferr_q : mode0_q;               // [R8]
  end

  always_comb begin
    ctrl_view                  = `PCR_BYTE_ZERO;
    ctrl_view[`PCR_BIT_IDLE]   = idle_q;
    ctrl_view[`PCR_BIT_PWR_DOWN] = pwr_down_q;
    ctrl_view[`PCR_BIT_GF_LO]  = gf_lo_q;
    ctrl_view[`PCR_BIT_GF_HI]  = gf_hi_q;
    ctrl_view[`PCR_BIT_OFF_FLAG] = off_flag_q;
    ctrl_view[`PCR_BIT_RSVD]   = rsvd_q;                   // [R4]
    ctrl_view[`PCR_BIT_FESEL]  = fesel_q;
  end

  // events into the sticky status block
  always_comb begin
    ev_now                   = `PCR_EV_ZERO;
    ev_now[`PCR_EV_IDLE_END] = idle_q && INT_EVENT;
    ev_now[`PCR_EV_WARM]     = warm_rst && !warm_rst_d_q;
    ev_now[`PCR_EV_FRAME]    = FRAME_ERR_EVENT;
  end

  assign evb.evt     = ev_now;
  assign evb.wr_clr  = status_wr;
  assign evb.wr_mask = mask_wr;
  assign evb.wdata   = WDATA[`PCR_EV_W-1:0];

  event_status u_evt (
    .clk   (CLK),
    .rst_b (RST_B),
    .ev    (evb.core)
  );

  // read data stands only in the cycle after the strobe
  always_comb begin
    rdata_d = `PCR_BYTE_ZERO;
    if (RD) begin
      if (ADDR == `PCR_OFF_CTRL) begin
        rdata_d = ctrl_view;
      end else if (ADDR == `PCR_OFF_STATUS) begin
        rdata_d[`PCR_EV_W-1:0] = evb.status;
      end else if (ADDR == `PCR_OFF_MASK) begin
        rdata_d[`PCR_EV_W-1:0] = evb.mask;
      end else if (ADDR == `PCR_OFF_SERTOP) begin
        rdata_d[`PCR_BIT_SERTOP] = sertop_bit;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_q <= `PCR_BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA                = rdata_q;
  assign IDLE_MODE            = idle_q;
  assign POWER_DOWN_MODE      = pwr_down_q;
  assign SERIAL_MODE_BIT_ZERO = mode0_q;
  assign FRAMING_ERROR_FLAG   = ferr_q;
  assign IRQ                  = evb.irq;

  property p_warm_clears;
    @(posedge CLK) disable iff (!RST_B)
    warm_rst |=> !(|{fesel_q, gf_hi_q, gf_lo_q, pwr_down_q, idle_q});
  endproperty
  a_warm_clears: assert property (p_warm_clears) // [R1]
    else $error("warm reset left a control bit set");

  property p_off_flag_rise;
    @(posedge CLK) disable iff (!RST_B)
    $rose(off_flag_q) |-> $past(ctrl_wr)
                          && $past(WDATA[`PCR_BIT_OFF_FLAG]);
  endproperty
  a_off_flag_rise: assert property (p_off_flag_rise) // [R2]
    else $error("power-off flag rose without a write");

  property p_off_flag_warm;
    @(posedge CLK) disable iff (!RST_B)
    (warm_rst && !ctrl_wr) |=> off_flag_q == $past(off_flag_q);
  endproperty
  a_off_flag_warm: assert property (p_off_flag_warm) // [R3]
    else $error("warm reset changed the power-off flag");

  property p_ctrl_read;
    @(posedge CLK) disable iff (!RST_B)
    ctrl_rd |=> RDATA[`PCR_BIT_RSVD] == $past(rsvd_q)
                && !RDATA[`PCR_BIT_TOP]
                && RDATA[`PCR_BIT_OFF_FLAG] == $past(off_flag_q);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) // [R4]
    else $error("control read returned wrong bits");

  property p_gf_hold;
    @(posedge CLK) disable iff (!RST_B)
    (!ctrl_wr && !warm_rst) |=> $stable({gf_hi_q, gf_lo_q});
  endproperty
  a_gf_hold: assert property (p_gf_hold) // [R5]
    else $error("general flag changed without a write");

  property p_pwr_down_enter;
    @(posedge CLK) disable iff (!RST_B)
    (ctrl_wr && WDATA[`PCR_BIT_PWR_DOWN] && !warm_rst)
      |=> POWER_DOWN_MODE;
  endproperty
  a_pwr_down_enter: assert property (p_pwr_down_enter) // [R6]
    else $error("power-down request not taken");

  property p_idle_end;
    @(posedge CLK) disable iff (!RST_B)
    (INT_EVENT || warm_rst) |=> !IDLE_MODE;
  endproperty
  a_idle_end: assert property (p_idle_end) // [R7]
    else $error("idle not ended by interrupt or reset");

  property p_sertop_read;
    @(posedge CLK) disable iff (!RST_B)
    sertop_rd |=> RDATA[`PCR_BIT_SERTOP]
                  == ($past(fesel_q) ? $past(ferr_q) : $past(mode0_q));
  endproperty
  a_sertop_read: assert property (p_sertop_read) // [R8]
    else $error("serial top bit read from the wrong source");

  property p_frame_irq;
    @(posedge CLK) disable iff (!RST_B)
    (FRAME_ERR_EVENT && evb.mask[`PCR_EV_FRAME]) |=> IRQ;
  endproperty
  a_frame_irq: assert property (p_frame_irq) // [R8]
    else $error("framing error event raised no interrupt");

endmodule

// ---- verification/test_power_control_register.sv ----
`timescale 1ns/10ps
`include "pcr_consts.svh"

module test_power_control_register;
  logic            clk;
  logic            rst_b;
  logic            warm_rst;
  logic            int_event;
  logic            frame_err_event;
  pcr_pkg::addr_t  addr;
  pcr_pkg::byte_t  wdata;
  logic            wr;
  logic            rd;
  pcr_pkg::byte_t  rdata;
  logic            idle_mode;
  logic            power_down_mode;
  logic            serial_mode_bit_zero;
  logic            framing_error_flag;
  logic            irq;
  logic            rd_seen;
  pcr_pkg::byte_t  outs;
  pcr_pkg::byte_t  exp_q[$];
  pcr_pkg::byte_t  v;
  int              mismatches;
  int              cmp_count;
  integer          seed;
  int              i;

  // level outputs: 4 irq, 3 frame err, 2 mode bit, 1 power-down, 0 idle
  assign outs = {3'h0, irq, framing_error_flag, serial_mode_bit_zero,
                 power_down_mode, idle_mode};

  power_control_register dut (
    .CLK                  (clk),
    .RST_B                (rst_b),
    .WARM_RST             (warm_rst),
    .INT_EVENT            (int_event),
    .FRAME_ERR_EVENT      (frame_err_event),
    .ADDR                 (addr),
    .WDATA                (wdata),
    .WR                   (wr),
    .RD                   (rd),
    .RDATA                (rdata),
    .IDLE_MODE            (idle_mode),
    .POWER_DOWN_MODE      (power_down_mode),
    .SERIAL_MODE_BIT_ZERO (serial_mode_bit_zero),
    .FRAMING_ERROR_FLAG   (framing_error_flag),
    .IRQ                  (irq)
  );

  always #2 clk = ~clk;

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input pcr_pkg::byte_t seen,
                     input pcr_pkg::byte_t exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input pcr_pkg::addr_t a, input pcr_pkg::byte_t d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // the expectation is queued here; the monitor compares it a cycle later
  task automatic rd_reg(input pcr_pkg::addr_t a, input pcr_pkg::byte_t e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd   <= 1'b0;
  endtask

  task automatic ev(input int k);
    @(posedge clk);
    if (k == 0)
      int_event <= 1'b1;
    else
      frame_err_event <= 1'b1;
    @(posedge clk);
    int_event       <= 1'b0;
    frame_err_event <= 1'b0;
  endtask

  // sample on the falling edge so no edge update races the check
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  // held past the 2-flop sync so the warm effect surely lands
  task automatic warm;
    @(posedge clk);
    warm_rst <= 1'b1;
    repeat (4) @(posedge clk);
    warm_rst <= 1'b0;
    settle();
  endtask

  task automatic cold;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  always @(posedge clk) rd_seen <= rd;

  always @(negedge clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("[ERR] rdata expected none seen %h", rdata);
      end else
        chk("rdata", rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    clk = 1'b0; rst_b = 1'b0; warm_rst = 1'b0; int_event = 1'b0;
    frame_err_event = 1'b0; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    seed = 32'h110f;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(4'h0, 8'h10);
    rd_reg(4'h1, 8'h00);
    rd_reg(4'h2, 8'h00);
    settle();
    chk("outs", outs, 8'h00);
    // unmapped index: write dropped, read zero
    wr_reg(4'h9, 8'hff);
    rd_reg(4'h9, 8'h00);
    rd_reg(4'h0, 8'h10);
    for (i = 0; i < 4; i++) begin
      v = pcr_pkg::byte_t'($random(seed));
      v = (v & 8'h0c) | 8'h10;
      wr_reg(4'h0, v);
      rd_reg(4'h0, v);
      settle();
      chk("outs", outs, 8'h00);
    end
    wr_reg(4'h0, 8'h11);
    settle();
    chk("outs", outs, 8'h01);
    ev(0);
    settle();
    chk("outs", outs, 8'h00);
    rd_reg(4'h0, 8'h10);
    rd_reg(4'h1, 8'h01);
    wr_reg(4'h1, 8'h07);
    rd_reg(4'h1, 8'h00);
    wr_reg(4'h0, 8'h1e);
    settle();
    chk("outs", outs, 8'h02);
    warm();
    chk("outs", outs, 8'h00);
    rd_reg(4'h0, 8'h10);
    rd_reg(4'h1, 8'h02);
    wr_reg(4'h1, 8'h07);
    wr_reg(4'h0, 8'h00);
    warm();
    rd_reg(4'h0, 8'h00);
    cold();
    rd_reg(4'h0, 8'h10);
    wr_reg(4'h3, 8'h01);
    settle();
    chk("outs", outs, 8'h04);
    rd_reg(4'h3, 8'h01);
    wr_reg(4'h0, 8'h50);
    rd_reg(4'h3, 8'h00);
    ev(1);
    settle();
    chk("outs", outs, 8'h0c);
    rd_reg(4'h3, 8'h01);
    rd_reg(4'h1, 8'h04);
    wr_reg(4'h2, 8'h04);
    rd_reg(4'h2, 8'h04);
    settle();
    chk("outs", outs, 8'h1c);
    wr_reg(4'h1, 8'h04);
    settle();
    chk("outs", outs, 8'h0c);
    wr_reg(4'h3, 8'h00);
    settle();
    chk("outs", outs, 8'h04);
    // a framing error with its mask open must raise the interrupt line
    ev(1);
    settle();
    chk("outs", outs, 8'h1c);
    rd_reg(4'h1, 8'h04);
    wr_reg(4'h1, 8'h04);
    settle();
    chk("outs", outs, 8'h0c);
    wr_reg(4'h0, 8'h10);
    rd_reg(4'h3, 8'h01);
    for (i = 0; i < 10 && exp_q.size() != 0; i++)
      @(posedge clk);
    if (exp_q.size() != 0)
      mismatches++;
    print_verdict();
  end
endmodule
